// ---- common/sri_pkg.sv ----
/*
 * Constants, function codes and enumerations for the shift, rotate and
 * increment/decrement datapath.
 * Assumes one synchronous clock domain shared with the surrounding CPU.
 */
`default_nettype none

package sri_pkg;

	// ----------------------------------------------------------------
	// widths and sizes
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int DWORD_W = 32;
	localparam int FUNC_W = 10;
	localparam int CNT_W = 6;
	localparam int MEM_WORDS = 16;
	localparam int PTR_W = 4;
	localparam int IDX_REGS = 8;
	localparam int IDX_SEL_W = 3;
	localparam int ADDR_W = 32;
	localparam int BIT_NUM_W = 4;
	localparam int DIGIT_W = 4;
	localparam int BCD_DIGITS = 8;

	// ----------------------------------------------------------------
	// function codes, binary value of the decimal code
	// ----------------------------------------------------------------
	localparam logic [FUNC_W-1:0] FUNC_INDEX_ADDRESS_LOAD = 10'h230;
	localparam logic [FUNC_W-1:0] FUNC_INDEX_PV_ADDRESS_LOAD = 10'h231;
	localparam logic [FUNC_W-1:0] FUNC_BIT_SHIFT_REGISTER = 10'h00a;
	localparam logic [FUNC_W-1:0] FUNC_REVERSIBLE_SHIFT_REGISTER = 10'h054;
	localparam logic [FUNC_W-1:0] FUNC_WHOLE_WORD_SHIFT = 10'h010;
	localparam logic [FUNC_W-1:0] FUNC_ARITH_SHIFT_LEFT = 10'h019;
	localparam logic [FUNC_W-1:0] FUNC_DOUBLE_ARITH_SHIFT_LEFT = 10'h23a;
	localparam logic [FUNC_W-1:0] FUNC_ARITH_SHIFT_RIGHT = 10'h01a;
	localparam logic [FUNC_W-1:0] FUNC_DOUBLE_ARITH_SHIFT_RIGHT = 10'h23b;
	localparam logic [FUNC_W-1:0] FUNC_ROTATE_LEFT = 10'h01b;
	localparam logic [FUNC_W-1:0] FUNC_DOUBLE_ROTATE_LEFT = 10'h23c;
	localparam logic [FUNC_W-1:0] FUNC_ROTATE_RIGHT = 10'h01c;
	localparam logic [FUNC_W-1:0] FUNC_DOUBLE_ROTATE_RIGHT = 10'h23d;
	localparam logic [FUNC_W-1:0] FUNC_DIGIT_SHIFT_LEFT = 10'h04a;
	localparam logic [FUNC_W-1:0] FUNC_DIGIT_SHIFT_RIGHT = 10'h04b;
	localparam logic [FUNC_W-1:0] FUNC_MULTI_SHIFT_LEFT = 10'h244;
	localparam logic [FUNC_W-1:0] FUNC_MULTI_SHIFT_RIGHT = 10'h245;
	localparam logic [FUNC_W-1:0] FUNC_DOUBLE_MULTI_SHIFT_LEFT = 10'h246;
	localparam logic [FUNC_W-1:0] FUNC_DOUBLE_MULTI_SHIFT_RIGHT = 10'h247;
	localparam logic [FUNC_W-1:0] FUNC_INC_BIN = 10'h24e;
	localparam logic [FUNC_W-1:0] FUNC_DOUBLE_INC_BIN = 10'h24f;
	localparam logic [FUNC_W-1:0] FUNC_DEC_BIN = 10'h250;
	localparam logic [FUNC_W-1:0] FUNC_DOUBLE_DEC_BIN = 10'h251;
	localparam logic [FUNC_W-1:0] FUNC_INC_BCD = 10'h252;
	localparam logic [FUNC_W-1:0] FUNC_DOUBLE_INC_BCD = 10'h253;
	localparam logic [FUNC_W-1:0] FUNC_DEC_BCD = 10'h254;
	localparam logic [FUNC_W-1:0] FUNC_DOUBLE_DEC_BCD = 10'h255;

	// ----------------------------------------------------------------
	// counts, digits, address map
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] SHIFT_ONE = 6'h01;
	localparam logic [CNT_W-1:0] SHIFT_DIGIT = 6'h04;
	localparam logic [WORD_W-1:0] WORD_ONE = 16'h0001;
	localparam logic [DWORD_W-1:0] DWORD_ONE = 32'h0000_0001;
	localparam logic [DIGIT_W-1:0] DIGIT_ZERO = 4'h0;
	localparam logic [DIGIT_W-1:0] DIGIT_ONE = 4'h1;
	localparam logic [DIGIT_W-1:0] DIGIT_MAX = 4'h9;
	localparam logic [ADDR_W-1:0] WORD_AREA_BASE = 32'h0001_0000;
	localparam logic [ADDR_W-1:0] BIT_AREA_BASE = 32'h0010_0000;
	localparam logic [ADDR_W-1:0] TIMER_FLAG_BASE = 32'h0008_0000;
	localparam logic [ADDR_W-1:0] TIMER_PV_BASE = 32'h0009_0000;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ADDR_WORD = 2'h0,
		ADDR_BIT = 2'h1,
		ADDR_DONE_FLAG = 2'h2
	} sri_addr_kind_t;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_WALK = 1'b1
	} sri_state_t;

	typedef enum logic [1:0] {
		WALK_BIT_LEFT = 2'h0,
		WALK_BIT_RIGHT = 2'h1,
		WALK_WORD = 2'h3
	} sri_walk_t;

endpackage

`default_nettype wire

// ---- common/sri_bcd_if.sv ----
/*
 * Carrier between the datapath core and its BCD stepper.
 * Assumes a purely combinational stepper.
 */
`default_nettype none

interface sri_bcd_if;
	import sri_pkg::*;
	logic [DWORD_W-1:0] value;
	logic down;
	logic [DWORD_W-1:0] stepped;
	modport core (output value, output down, input stepped);
	modport stepper (input value, input down, output stepped);
endinterface

`default_nettype wire

// ---- core/sri_bcd_step.sv ----
/*
 * Eight-digit BCD add-one / subtract-one stepper.
 * Assumes the caller takes the low four digits for single-word use.
 */
`default_nettype none

module sri_bcd_step
	import sri_pkg::*;
(
	sri_bcd_if.stepper bcd // value in, stepped value out
);
	logic [BCD_DIGITS:0] chain;

	assign chain[0] = 1'b1;

	// ----------------------------------------------------------------
	// digit ripple
	// ----------------------------------------------------------------
	// digits above 9 are treated as 9 when counting up, so junk still wraps
	for (genvar d = 0; d < BCD_DIGITS; d++) begin : g_digit
		logic [DIGIT_W-1:0] dig;
		assign dig = bcd.value[d*DIGIT_W +: DIGIT_W];
		assign chain[d+1] = chain[d] &
			(bcd.down ? (dig == DIGIT_ZERO) : (dig >= DIGIT_MAX));
		assign bcd.stepped[d*DIGIT_W +: DIGIT_W] = !chain[d] ? dig :
			bcd.down ? ((dig == DIGIT_ZERO) ? DIGIT_MAX : dig - DIGIT_ONE) :
			((dig >= DIGIT_MAX) ? DIGIT_ZERO : dig + DIGIT_ONE);
	end

endmodule // sri_bcd_step

`default_nettype wire

// ---- core/sri_unit.sv ----
/*
 * Shift, rotate, shift-register, index-address and increment/decrement
 * datapath with its own carry flag, word array and index registers.
 * Assumes requests come from logic on the same clock, one at a time.
 */
`default_nettype none

module sri_unit
	import sri_pkg::*;
(
	input wire logic clk, // 20 MHz core clock
	input wire logic reset, // synchronous, active high
	input wire logic reqValid, // request strobe
	input wire logic [FUNC_W-1:0] funcCode, // function code
	input wire logic [DWORD_W-1:0] operand, // {next word, target word}
	input wire logic [CNT_W-1:0] shiftCount, // bit count for n-bit shifts
	input wire logic shiftLeft, // direction for reversible register
	input wire logic fillBit, // bit fed into shift registers
	input wire logic [PTR_W-1:0] startWord, // first word of range
	input wire logic [PTR_W-1:0] endWord, // last word of range
	input wire logic [IDX_SEL_W-1:0] idxSel, // index register to load
	input wire logic [1:0] addrKind, // word, bit or completion flag
	input wire logic [BIT_NUM_W-1:0] bitNum, // bit number for bit address
	input wire logic memWrEn, // word array write strobe
	input wire logic [PTR_W-1:0] memWrAddr, // word array write address
	input wire logic [WORD_W-1:0] memWrData, // word array write data
	input wire logic [PTR_W-1:0] memRdAddr, // word array read address
	input wire logic [IDX_SEL_W-1:0] idxRdSel, // index register to read
	output logic busy, // range walk in progress
	output logic done, // one-cycle completion pulse
	output logic badRequest, // last request was refused
	output logic [DWORD_W-1:0] result, // last result
	output logic carryFlag, // carry flag
	output logic [WORD_W-1:0] memRdData, // word array read data
	output logic [ADDR_W-1:0] idxRdData // index register read data
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		sri_state_t st;
		sri_walk_t walk;
		logic [PTR_W-1:0] ptr;
		logic [PTR_W-1:0] stop;
		logic chainBit;
		logic [WORD_W-1:0] inWord;
		logic [MEM_WORDS-1:0][WORD_W-1:0] mem;
		logic [IDX_REGS-1:0][ADDR_W-1:0] idx;
		logic [DWORD_W-1:0] result;
		logic carry;
		logic busy;
		logic done;
		logic bad;
		logic [WORD_W-1:0] rdData;
		logic [ADDR_W-1:0] idxRd;
	} sri_core_t;

	localparam sri_core_t CORE_RESET = '0;

	sri_core_t s_reg;
	sri_core_t s_next;
	logic accept;
	logic [DWORD_W:0] sh;
	sri_bcd_if bcd ();

	sri_bcd_step u_bcd (
		.bcd(bcd)
	);

	assign bcd.value = operand;
	assign bcd.down = (funcCode == FUNC_DEC_BCD) || (funcCode == FUNC_DOUBLE_DEC_BCD);
	assign accept = reqValid && (s_reg.st == ST_IDLE);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// returns {bit shifted out last, shifted value}; a zero count gives carry 0
	function automatic logic [DWORD_W:0] shiftOut(input logic [DWORD_W-1:0] val,
			input logic wide, input logic left, input logic [CNT_W-1:0] n);
		logic [DWORD_W:0] t;
		logic [DWORD_W:0] r;
		t = {1'b0, val} << n;
		r = {val, 1'b0} >> n;
		if (left) begin
			if (!wide) begin
				t = {t[WORD_W], {WORD_W{1'b0}}, t[WORD_W-1:0]};
			end
		end else begin
			t = {r[0], r[DWORD_W:1]};
		end
		return t;
	endfunction

	function automatic logic [ADDR_W-1:0] idxAddress(input logic pv,
			input logic [1:0] kind, input logic [WORD_W-1:0] num,
			input logic [BIT_NUM_W-1:0] bitSel);
		logic [ADDR_W-1:0] a;
		a = WORD_AREA_BASE + {{(ADDR_W-WORD_W){1'b0}}, num};
		if (pv) begin
			a = TIMER_PV_BASE + {{(ADDR_W-WORD_W){1'b0}}, num};
		end else if (kind == ADDR_BIT) begin
			a = BIT_AREA_BASE +
				{{(ADDR_W-WORD_W-BIT_NUM_W){1'b0}}, num, bitSel};
		end else if (kind == ADDR_DONE_FLAG) begin
			a = TIMER_FLAG_BASE + {{(ADDR_W-WORD_W){1'b0}}, num};
		end
		return a;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.rdData = s_reg.mem[memRdAddr];
		s_next.idxRd = s_reg.idx[idxRdSel];
		sh = shiftOut(operand, 1'b1, 1'b1, SHIFT_ONE);
		unique case (s_reg.st)
			ST_IDLE: begin
				if (memWrEn) begin
					s_next.mem[memWrAddr] = memWrData;
				end
				if (reqValid) begin
					s_next.done = 1'b1;
					s_next.bad = 1'b0;
					case (funcCode)
						FUNC_ARITH_SHIFT_LEFT: begin
							sh = shiftOut({{WORD_W{1'b0}}, operand[WORD_W-1:0]}, 1'b0, 1'b1,
								SHIFT_ONE);
							{s_next.carry, s_next.result} = sh;
						end
						FUNC_DOUBLE_ARITH_SHIFT_LEFT: begin
							sh = shiftOut(operand, 1'b1, 1'b1, SHIFT_ONE);
							{s_next.carry, s_next.result} = sh;
						end
						FUNC_ARITH_SHIFT_RIGHT: begin
							sh = shiftOut({{WORD_W{1'b0}}, operand[WORD_W-1:0]}, 1'b0, 1'b0,
								SHIFT_ONE);
							{s_next.carry, s_next.result} = sh;
						end
						FUNC_DOUBLE_ARITH_SHIFT_RIGHT: begin
							sh = shiftOut(operand, 1'b1, 1'b0, SHIFT_ONE);
							{s_next.carry, s_next.result} = sh;
						end
						FUNC_ROTATE_LEFT: begin
							s_next.result = {{WORD_W{1'b0}}, operand[WORD_W-2:0], s_reg.carry};
							s_next.carry = operand[WORD_W-1];
						end
						FUNC_DOUBLE_ROTATE_LEFT: begin
							s_next.result = {operand[DWORD_W-2:0], s_reg.carry};
							s_next.carry = operand[DWORD_W-1];
						end
						FUNC_ROTATE_RIGHT: begin
							s_next.result = {{WORD_W{1'b0}}, s_reg.carry,
								operand[WORD_W-1:1]};
							s_next.carry = operand[0];
						end
						FUNC_DOUBLE_ROTATE_RIGHT: begin
							s_next.result = {s_reg.carry, operand[DWORD_W-1:1]};
							s_next.carry = operand[0];
						end
						// digit shifts leave the carry alone
						FUNC_DIGIT_SHIFT_LEFT: begin
							sh = shiftOut({{WORD_W{1'b0}}, operand[WORD_W-1:0]}, 1'b0, 1'b1,
								SHIFT_DIGIT);
							s_next.result = sh[DWORD_W-1:0];
						end
						FUNC_DIGIT_SHIFT_RIGHT: begin
							sh = shiftOut({{WORD_W{1'b0}}, operand[WORD_W-1:0]}, 1'b0, 1'b0,
								SHIFT_DIGIT);
							s_next.result = sh[DWORD_W-1:0];
						end
						FUNC_MULTI_SHIFT_LEFT: begin
							sh = shiftOut({{WORD_W{1'b0}}, operand[WORD_W-1:0]}, 1'b0, 1'b1,
								shiftCount);
							{s_next.carry, s_next.result} = sh;
						end
						FUNC_DOUBLE_MULTI_SHIFT_LEFT: begin
							sh = shiftOut(operand, 1'b1, 1'b1, shiftCount);
							{s_next.carry, s_next.result} = sh;
						end
						FUNC_MULTI_SHIFT_RIGHT: begin
							sh = shiftOut({{WORD_W{1'b0}}, operand[WORD_W-1:0]}, 1'b0, 1'b0,
								shiftCount);
							{s_next.carry, s_next.result} = sh;
						end
						FUNC_DOUBLE_MULTI_SHIFT_RIGHT: begin
							sh = shiftOut(operand, 1'b1, 1'b0, shiftCount);
							{s_next.carry, s_next.result} = sh;
						end
						FUNC_INC_BIN: begin
							s_next.result = {{WORD_W{1'b0}}, operand[WORD_W-1:0] + WORD_ONE};
						end
						FUNC_DEC_BIN: begin
							s_next.result = {{WORD_W{1'b0}}, operand[WORD_W-1:0] - WORD_ONE};
						end
						FUNC_DOUBLE_INC_BIN: begin
							s_next.result = operand + DWORD_ONE;
						end
						FUNC_DOUBLE_DEC_BIN: begin
							s_next.result = operand - DWORD_ONE;
						end
						FUNC_INC_BCD, FUNC_DEC_BCD: begin
							s_next.result = {{WORD_W{1'b0}}, bcd.stepped[WORD_W-1:0]};
						end
						FUNC_DOUBLE_INC_BCD, FUNC_DOUBLE_DEC_BCD: begin
							s_next.result = bcd.stepped;
						end
						FUNC_INDEX_ADDRESS_LOAD, FUNC_INDEX_PV_ADDRESS_LOAD: begin
							s_next.result = idxAddress(funcCode == FUNC_INDEX_PV_ADDRESS_LOAD,
								addrKind, operand[WORD_W-1:0], bitNum);
							s_next.idx[idxSel] = s_next.result;
						end
						FUNC_BIT_SHIFT_REGISTER, FUNC_REVERSIBLE_SHIFT_REGISTER,
						FUNC_WHOLE_WORD_SHIFT: begin
							// an inverted range is refused rather than wrapped
							if (startWord > endWord) begin
								s_next.bad = 1'b1;
							end else begin
								s_next.done = 1'b0;
								s_next.busy = 1'b1;
								s_next.st = ST_WALK;
								s_next.chainBit = fillBit;
								s_next.inWord = operand[WORD_W-1:0];
								s_next.walk = WALK_BIT_LEFT;
								s_next.ptr = startWord;
								s_next.stop = endWord;
								if (funcCode == FUNC_WHOLE_WORD_SHIFT ||
										(funcCode == FUNC_REVERSIBLE_SHIFT_REGISTER && !shiftLeft)) begin
									s_next.walk = (funcCode == FUNC_WHOLE_WORD_SHIFT) ?
										WALK_WORD : WALK_BIT_RIGHT;
									s_next.ptr = endWord;
									s_next.stop = startWord;
								end
							end
						end
						default: begin
							s_next.bad = 1'b1;
						end
					endcase
				end
			end
			ST_WALK: begin
				case (s_reg.walk)
					WALK_BIT_LEFT: begin
						s_next.mem[s_reg.ptr] = {s_reg.mem[s_reg.ptr][WORD_W-2:0],
							s_reg.chainBit};
						s_next.chainBit = s_reg.mem[s_reg.ptr][WORD_W-1];
						s_next.ptr = s_reg.ptr + 1'b1;
					end
					WALK_BIT_RIGHT: begin
						s_next.mem[s_reg.ptr] = {s_reg.chainBit,
							s_reg.mem[s_reg.ptr][WORD_W-1:1]};
						s_next.chainBit = s_reg.mem[s_reg.ptr][0];
						s_next.ptr = s_reg.ptr - 1'b1;
					end
					WALK_WORD: begin
						// walking down from the end word keeps every copy from a fresh source
						s_next.mem[s_reg.ptr] = (s_reg.ptr == s_reg.stop) ? s_reg.inWord :
							s_reg.mem[s_reg.ptr - 1'b1];
						s_next.ptr = s_reg.ptr - 1'b1;
					end
					default: begin
						s_next.stop = s_reg.ptr;
					end
				endcase
				if (s_reg.ptr == s_reg.stop) begin
					s_next.st = ST_IDLE;
					s_next.busy = 1'b0;
					s_next.done = 1'b1;
					s_next.ptr = s_reg.ptr;
					s_next.result = {{WORD_W{1'b0}}, s_next.mem[s_reg.ptr]};
					if (s_reg.walk != WALK_WORD) begin
						s_next.carry = s_next.chainBit;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_reg <= CORE_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign busy = s_reg.busy;
	assign done = s_reg.done;
	assign badRequest = s_reg.bad;
	assign result = s_reg.result;
	assign carryFlag = s_reg.carry;
	assign memRdData = s_reg.rdData;
	assign idxRdData = s_reg.idxRd;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_walkStart;
		accept && (funcCode == FUNC_WHOLE_WORD_SHIFT) && (startWord == endWord);
	endsequence
	sequence s_walkEnd;
		busy && !done ##1 done && !busy;
	endsequence

	property p_shl;
		accept && funcCode == FUNC_ARITH_SHIFT_LEFT |=> done &&
			result[WORD_W-1:0] == ($past(operand[WORD_W-1:0]) << 1) &&
			carryFlag == $past(operand[WORD_W-1]);
	endproperty
	a_shl: assert property (p_shl) else $error("left shift wrong");

	property p_shr2;
		accept && funcCode == FUNC_DOUBLE_ARITH_SHIFT_RIGHT |=>
			result == ($past(operand) >> 1) && carryFlag == $past(operand[0]);
	endproperty
	a_shr2: assert property (p_shr2) else $error("double right shift wrong");

	property p_rol;
		accept && funcCode == FUNC_ROTATE_LEFT |=>
			result[WORD_W-1:0] == {$past(operand[WORD_W-2:0]), $past(carryFlag)};
	endproperty
	a_rol: assert property (p_rol) else $error("rotate left wrong");

	property p_double_rotate_right_op;
		accept && funcCode == FUNC_DOUBLE_ROTATE_RIGHT |=>
			result == {$past(carryFlag), $past(operand[DWORD_W-1:1])};
	endproperty
	a_double_rotate_right_op: assert property (p_double_rotate_right_op) else $error("double rotate right wrong");

	property p_sld;
		accept && funcCode == FUNC_DIGIT_SHIFT_LEFT |=>
			result == {16'h0000, $past(operand[11:0]), 4'h0} && $stable(carryFlag);
	endproperty
	a_sld: assert property (p_sld) else $error("digit shift wrong");

	property p_dec2;
		accept && funcCode == FUNC_DOUBLE_DEC_BIN |=> result == $past(operand) - 32'h1;
	endproperty
	a_dec2: assert property (p_dec2) else $error("double decrement wrong");

	property p_bcd;
		accept && funcCode == FUNC_INC_BCD && operand[WORD_W-1:0] == 16'h9999 |=>
			result == 32'h0000_0000;
	endproperty
	a_bcd: assert property (p_bcd) else $error("bcd wrap wrong");

	// the read select of the edge after the load decides what the read port shows
	property p_pv;
		accept && funcCode == FUNC_INDEX_PV_ADDRESS_LOAD |=> ##1
			$past(idxRdSel) != $past(idxSel, 2) ||
			idxRdData == TIMER_PV_BASE + $past(operand[15:0], 2);
	endproperty
	a_pv: assert property (p_pv) else $error("index load wrong");

	property p_whole_word_shift_op;
		s_walkStart |=> s_walkEnd;
	endproperty
	a_whole_word_shift_op: assert property (p_whole_word_shift_op) else $error("word shift timing wrong");

endmodule // sri_unit

`default_nettype wire

// ---- test/sri_unit_bench.sv ----
/*
 * Self-checking bench for sri_unit: shifts, rotates, index loads,
 * inc/dec, range walks and refusals.
 * Assumes the unit stands alone, every port driven from here.
 */
`default_nettype none

module sri_unit_bench
	import sri_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {logic chk; logic bad; logic cy; logic [31:0] res;} sri_note_t;

	// ------------------------------------------------------------
	// stimulus and model state
	// ------------------------------------------------------------
	logic clk = 1'h0;
	logic reset = 1'h1;
	logic reqValid = 1'h0, shiftLeft = 1'h0, fillBit = 1'h0, memWrEn = 1'h0;
	logic [FUNC_W-1:0] funcCode = '0;
	logic [DWORD_W-1:0] operand = '0;
	logic [CNT_W-1:0] shiftCount = '0;
	logic [PTR_W-1:0] startWord = '0, endWord = '0, memWrAddr = '0, memRdAddr = '0;
	logic [IDX_SEL_W-1:0] idxSel = '0, idxRdSel = '0, ix = '0;
	logic [1:0] addrKind = '0;
	logic [BIT_NUM_W-1:0] bitNum = '0;
	logic [WORD_W-1:0] memWrData = '0, memRdData;
	logic busy, done, badRequest, carryFlag, mc = 1'h0;
	logic [DWORD_W-1:0] result, mr = '0, v;
	logic [ADDR_W-1:0] idxRdData;
	logic [15:0] mm[16];
	logic [31:0] mi[8];
	sri_note_t notes[$];
	int mismatches = 0, checks = 0, cycles = 0, seed = 32'hc0146194;
	localparam logic [9:0] OPS[22] = '{
		FUNC_ARITH_SHIFT_LEFT, FUNC_DOUBLE_ARITH_SHIFT_LEFT, FUNC_ARITH_SHIFT_RIGHT,
		FUNC_DOUBLE_ARITH_SHIFT_RIGHT, FUNC_ROTATE_LEFT, FUNC_DOUBLE_ROTATE_LEFT,
		FUNC_ROTATE_RIGHT, FUNC_DOUBLE_ROTATE_RIGHT, FUNC_DIGIT_SHIFT_LEFT,
		FUNC_DIGIT_SHIFT_RIGHT, FUNC_MULTI_SHIFT_LEFT, FUNC_MULTI_SHIFT_RIGHT,
		FUNC_DOUBLE_MULTI_SHIFT_LEFT, FUNC_DOUBLE_MULTI_SHIFT_RIGHT, FUNC_INC_BIN,
		FUNC_DEC_BIN, FUNC_DOUBLE_INC_BIN, FUNC_DOUBLE_DEC_BIN, FUNC_INC_BCD,
		FUNC_DEC_BCD, FUNC_DOUBLE_INC_BCD, FUNC_DOUBLE_DEC_BCD};
	// counts straddle both widths so the carry edge cases come up
	localparam logic [5:0] CN[6] = '{6'h00, 6'h01, 6'h10, 6'h11, 6'h20, 6'h21};
	localparam logic [31:0] EB[3] = '{32'h0, 32'hffffffff, 32'h8000ffff};
	localparam logic [31:0] ED[3] = '{32'h0, 32'h99999999, 32'h00019999};

	sri_unit i_dut (.clk, .reset, .reqValid, .funcCode, .operand, .shiftCount, .shiftLeft,
		.fillBit, .startWord, .endWord, .idxSel, .addrKind, .bitNum, .memWrEn, .memWrAddr,
		.memWrData, .memRdAddr, .idxRdSel, .busy, .done, .badRequest, .result, .carryFlag,
		.memRdData, .idxRdData);

	initial begin
		forever #25 clk = ~clk;
	end

	// ------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------
	function automatic logic [31:0] bcd(input logic [31:0] d, input logic dn);
		logic go;
		go = 1'h1;
		for (int i = 0; i < 32; i += 4) begin
			if (go && !dn) begin
				go = d[i+:4] >= 4'h9;
				d[i+:4] = go ? 4'h0 : d[i+:4] + 4'h1;
			end else if (go) begin
				go = d[i+:4] == 4'h0;
				d[i+:4] = go ? 4'h9 : d[i+:4] - 4'h1;
			end
		end
		return d;
	endfunction

	function automatic logic [33:0] mdl(input logic [9:0] f, input logic [31:0] d,
			input logic [5:0] n);
		logic [15:0] w;
		logic [63:0] t;
		logic [31:0] a;
		w = d[15:0];
		a = {16'h0, w};
		case (f)
			FUNC_INDEX_ADDRESS_LOAD: return {1'h0, mc, addrKind == 2'h1 ?
				BIT_AREA_BASE + {12'h0, w, bitNum} :
				(addrKind == 2'h2 ? TIMER_FLAG_BASE : WORD_AREA_BASE) + a};
			FUNC_INDEX_PV_ADDRESS_LOAD: return {1'h0, mc, TIMER_PV_BASE + a};
			FUNC_ARITH_SHIFT_LEFT: return {1'h0, w[15], 16'h0, w[14:0], 1'h0};
			FUNC_ARITH_SHIFT_RIGHT: return {1'h0, w[0], 17'h0, w[15:1]};
			FUNC_DOUBLE_ARITH_SHIFT_LEFT: return {1'h0, d[31], d[30:0], 1'h0};
			FUNC_DOUBLE_ARITH_SHIFT_RIGHT: return {1'h0, d[0], 1'h0, d[31:1]};
			FUNC_ROTATE_LEFT: return {1'h0, w[15], 16'h0, w[14:0], mc};
			FUNC_ROTATE_RIGHT: return {1'h0, w[0], 16'h0, mc, w[15:1]};
			FUNC_DOUBLE_ROTATE_LEFT: return {1'h0, d[31], d[30:0], mc};
			FUNC_DOUBLE_ROTATE_RIGHT: return {1'h0, d[0], mc, d[31:1]};
			FUNC_DIGIT_SHIFT_LEFT: return {1'h0, mc, 16'h0, w[11:0], 4'h0};
			FUNC_DIGIT_SHIFT_RIGHT: return {1'h0, mc, 20'h0, w[15:4]};
			FUNC_MULTI_SHIFT_LEFT: begin
				t = {48'h0, w} << n;
				return {1'h0, t[16], 16'h0, t[15:0]};
			end
			FUNC_MULTI_SHIFT_RIGHT: begin
				t = {47'h0, w, 1'h0} >> n;
				return {1'h0, t[0], 16'h0, t[16:1]};
			end
			FUNC_DOUBLE_MULTI_SHIFT_LEFT: begin
				t = {32'h0, d} << n;
				return {1'h0, t[32], t[31:0]};
			end
			FUNC_DOUBLE_MULTI_SHIFT_RIGHT: begin
				t = {31'h0, d, 1'h0} >> n;
				return {1'h0, t[0], t[32:1]};
			end
			FUNC_INC_BIN: return {1'h0, mc, 16'h0, w + 16'h1};
			FUNC_DEC_BIN: return {1'h0, mc, 16'h0, w - 16'h1};
			FUNC_DOUBLE_INC_BIN: return {1'h0, mc, d + 32'h1};
			FUNC_DOUBLE_DEC_BIN: return {1'h0, mc, d - 32'h1};
			FUNC_INC_BCD, FUNC_DEC_BCD: begin
				a = bcd(a, f == FUNC_DEC_BCD);
				return {1'h0, mc, 16'h0, a[15:0]};
			end
			FUNC_DOUBLE_INC_BCD, FUNC_DOUBLE_DEC_BCD:
				return {1'h0, mc, bcd(d, f == FUNC_DOUBLE_DEC_BCD)};
			default: return {1'h1, mc, mr};
		endcase
	endfunction

	// ------------------------------------------------------------
	// drivers and checks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		checks++;
		if (e !== g) begin
			mismatches++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_done(input sri_note_t n);
		chk("done outputs", {n.bad, n.cy, n.res}, {badRequest, carryFlag, n.chk ? result : n.res});
	endtask

	// leaves reqValid high so single ops go back to back
	task automatic op(input logic [9:0] f, input logic [31:0] d, input logic [5:0] n);
		logic [33:0] e;
		@(posedge clk);
		#2;
		{addrKind, bitNum} = 6'($random(seed));
		idxSel = ix;
		// read back the register loaded by the previous request
		idxRdSel = idxSel - 3'h1;
		ix++;
		funcCode = f;
		operand = d;
		shiftCount = n;
		reqValid = 1'h1;
		e = mdl(f, d, n);
		mc = e[32];
		mr = e[31:0];
		if (f == FUNC_INDEX_ADDRESS_LOAD || f == FUNC_INDEX_PV_ADDRESS_LOAD) mi[idxSel] = mr;
		notes.push_back({1'h1, e});
	endtask

	task automatic walk(input logic [9:0] f, input int s, input int t, input logic l);
		int k, b;
		@(posedge clk);
		#2;
		v = $random(seed);
		funcCode = f;
		startWord = s[3:0];
		endWord = t[3:0];
		shiftLeft = l;
		fillBit = v[0];
		operand = v;
		reqValid = 1'h1;
		if (s > t) notes.push_back({2'h3, mc, mr});
		else begin
			if (f == FUNC_WHOLE_WORD_SHIFT) begin
				for (int i = t; i > s; i--) mm[i] = mm[i-1];
				mm[s] = v[15:0];
			end else if (l || f == FUNC_BIT_SHIFT_REGISTER) begin
				mc = mm[t][15];
				for (int i = t; i >= s; i--) mm[i] = {mm[i][14:0], i == s ? v[0] : mm[i-1][15]};
			end else begin
				mc = mm[s][0];
				for (int i = s; i <= t; i++) mm[i] = {i == t ? v[0] : mm[i+1][0], mm[i][15:1]};
			end
			// the last word written is not pinned down, so result goes unchecked
			notes.push_back({2'h0, mc, mr});
		end
		@(posedge clk);
		#2;
		reqValid = 1'h0;
		k = 0;
		b = 0;
		// a refusal answers at the take edge itself, so look before waiting
		while (done !== 1'h1 && k < 40) begin
			if (busy === 1'h1) b++;
			@(posedge clk);
			#2;
			k++;
		end
		chk("walk cycles", s > t ? 0 : t - s + 1, k);
		chk("busy cycles", s > t ? 0 : t - s + 1, b);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(negedge clk) begin
		if (done === 1'h1) begin
			if (notes.size() == 0) chk("unexpected done", 34'h0, 34'h1);
			else chk_done(notes.pop_front());
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		#2;
		reset = 1'h0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			#2;
			v = $random(seed);
			memWrEn = 1'h1;
			memWrAddr = i[3:0];
			memWrData = v[15:0];
			mm[i] = v[15:0];
		end
		@(posedge clk);
		#2;
		memWrEn = 1'h0;
		for (int i = 0; i < 24; i++) begin
			op(i[0] ? FUNC_INDEX_PV_ADDRESS_LOAD : FUNC_INDEX_ADDRESS_LOAD, $random(seed),
				6'h0);
		end
		op(10'h3ff, 32'h1234, 6'h0);
		walk(FUNC_WHOLE_WORD_SHIFT, 5, 2, 1'h0);
		for (int i = 0; i < 22; i++) begin
			for (int j = 0; j < 8; j++) begin
				v = $random(seed);
				if (OPS[i] >= FUNC_INC_BCD) v = j < 3 ? ED[j] : v & 32'h77777777;
				else if (j < 3) v = EB[j];
				op(OPS[i], v, j < 6 ? CN[j] : v[31:26]);
			end
		end
		walk(FUNC_WHOLE_WORD_SHIFT, 2, 5, 1'h0);
		walk(FUNC_WHOLE_WORD_SHIFT, 9, 9, 1'h0);
		walk(FUNC_BIT_SHIFT_REGISTER, 0, 15, 1'h0);
		walk(FUNC_REVERSIBLE_SHIFT_REGISTER, 7, 7, 1'h1);
		walk(FUNC_REVERSIBLE_SHIFT_REGISTER, 3, 9, 1'h0);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			#2;
			memRdAddr = i[3:0];
			idxRdSel = i[2:0];
			@(posedge clk);
			#2;
			chk("array word", mm[i], memRdData);
			if (i < 8) chk("index register", mi[i], idxRdData);
		end
		repeat (4) @(posedge clk);
		chk("notes left", 34'h0, notes.size());
		complete_run();
	end

endmodule // sri_unit_bench

`default_nettype wire
